// ===== hw/ahb_lite_slave_if.v
`timescale 1ns/1ps
module ahb_lite_slave_if (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave side.
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  // Register file side.
  output wire rd_en,
  output wire [7:0] rd_addr,
  output reg wr_en,
  output reg [7:0] wr_addr
);

  wire take;

  // Every transfer completes with no wait state and an OKAY response.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel & hready & htrans[1];
  assign rd_en = take & ~hwrite;
  assign rd_addr = {haddr[7:2], 2'b00};

  // Writes are held over to the data phase, where hwdata stands.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_en <= take & hwrite & (hsize == 3'b010);
      wr_addr <= {haddr[7:2], 2'b00};
    end
  end
endmodule

// ===== hw/ea_modifier.v
`timescale 1ns/1ps
module ea_modifier (
  // Pointer and mode from the load/store unit.
  input wire [15:0] base,
  input wire [2:0] mode,
  input wire word,
  // Address used by the access and the written-back pointer.
  output reg [15:0] ea,
  output reg [15:0] updated
);
`include "paged_addr_defs.vh"

  wire [15:0] step;
  wire [15:0] inc;
  wire [15:0] dec;

  // Word moves step by two bytes, byte moves by one.
  assign step = word ? 16'h0002 : 16'h0001;
  assign inc = base + step;
  assign dec = base - step;

  // Pre-modes address the modified pointer; post-modes address the old one.
  always @* begin
    ea = base;
    updated = base;
    case (mode)
      `MODE_PRE_INC: begin
        ea = inc;
        updated = inc;
      end
      `MODE_PRE_DEC: begin
        ea = dec;
        updated = dec;
      end
      `MODE_POST_INC: updated = inc;
      `MODE_POST_DEC: updated = dec;
      default: begin
        ea = base;
        updated = base;
      end
    endcase
  end
endmodule

// ===== hw/paged_addr_defs.vh
`ifndef PAGED_ADDR_DEFS_VH
`define PAGED_ADDR_DEFS_VH

// ****************************************
// Register map, byte addresses.
// ****************************************
`define REG_READ_PAGE 8'h00
`define REG_WRITE_PAGE 8'h04
`define REG_STATUS 8'h08
`define REG_MASK 8'h0c
`define REG_LAST_ADDR 8'h10
`define REG_TRAP_EA 8'h14

// ****************************************
// Widths and reset values.
// ****************************************
`define READ_PAGE_W 10
`define WRITE_PAGE_W 9
`define READ_PAGE_RESET 10'h001
`define WRITE_PAGE_RESET 9'h001
`define EXT_ADDR_W 24

// ****************************************
// Status and mask bit positions.
// ****************************************
`define ST_TRAP 0
`define ST_PSV 1
`define ST_W 2

// ****************************************
// Address modification modes.
// ****************************************
`define MODE_PLAIN 3'h0
`define MODE_PRE_INC 3'h1
`define MODE_PRE_DEC 3'h2
`define MODE_POST_INC 3'h3
`define MODE_POST_DEC 3'h4

`endif

// ===== hw/paged_data_space_address_gen.v
`timescale 1ns/1ps
module paged_data_space_address_gen (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // AHB-Lite register port.
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Load/store request from the core.
  input wire acc_valid,
  input wire acc_write,
  input wire acc_word,
  input wire [2:0] acc_mode,
  input wire [15:0] acc_base,
  // Translated access towards data memory.
  output reg mem_valid,
  output reg mem_write,
  output reg [23:0] mem_addr,
  output reg ptr_valid,
  output reg [15:0] ptr_update,
  // Hand-off to program space visibility.
  output reg psv_valid,
  output reg [23:0] psv_addr,
  // Trap and interrupt.
  output reg addr_error_trap,
  output wire irq
);
`include "paged_addr_defs.vh"

  // ****************************************
  // Declarations.
  // ****************************************
  reg [`READ_PAGE_W-1:0] data_read_page;
  reg [`WRITE_PAGE_W-1:0] data_write_page;
  reg [`ST_W-1:0] status;
  reg [`ST_W-1:0] mask;
  reg [23:0] last_addr;
  reg [15:0] trap_ea;
  reg [`ST_W-1:0] next_status;
  reg [31:0] next_rdata;
  wire rd_en;
  wire [7:0] rd_addr;
  wire wr_en;
  wire [7:0] wr_addr;
  wire [15:0] ea;
  wire [15:0] updated;
  wire upper;
  wire rd_req;
  wire wr_req;
  wire read_trap;
  wire read_psv;
  wire read_eds;
  wire [23:0] read_ext;
  wire [23:0] write_ext;

  // Joins a 9-bit page over the low 15 address bits.
  function [23:0] paged;
    input [8:0] page;
    input [15:0] addr;
    begin
      paged = {page, addr[14:0]};
    end
  endfunction

  // ****************************************
  // Bus slave and address modifier.
  // ****************************************
  ahb_lite_slave_if u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .wr_en(wr_en),
    .wr_addr(wr_addr)
  );

  // The modified address, not the raw pointer, feeds translation.
  ea_modifier u_mod (
    .base(acc_base),
    .mode(acc_mode),
    .word(acc_word),
    .ea(ea),
    .updated(updated)
  );

  // ****************************************
  // Translation decode.
  // ****************************************
  // Only the upper half of base data space is paged.
  assign upper = ea[15];
  assign rd_req = acc_valid & ~acc_write;
  assign wr_req = acc_valid & acc_write;
  // A paged read with a zero page never reaches memory.
  assign read_trap = rd_req & upper & (data_read_page == 10'h000);
  assign read_psv = rd_req & upper & data_read_page[9] & ~read_trap;
  assign read_eds = rd_req & upper & ~data_read_page[9] & ~read_trap;
  assign read_ext = paged(data_read_page[8:0], ea);
  assign write_ext = paged(data_write_page, ea);

  // ****************************************
  // Access outputs.
  // ****************************************
  // All access outputs are registered, one cycle after the request.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 24'h000000;
      psv_valid <= 1'b0;
      psv_addr <= 24'h000000;
      addr_error_trap <= 1'b0;
      ptr_valid <= 1'b0;
      ptr_update <= 16'h0000;
    end else begin
      mem_valid <= wr_req | (rd_req & ~upper) | read_eds;
      mem_write <= wr_req;
      psv_valid <= read_psv;
      psv_addr <= read_ext;
      addr_error_trap <= read_trap;
      // The pointer is written back even when the read traps.
      ptr_valid <= acc_valid;
      ptr_update <= updated;
      if (!upper) begin
        mem_addr <= {8'h00, ea};
      end else if (acc_write) begin
        mem_addr <= write_ext;
      end else begin
        mem_addr <= read_ext;
      end
    end
  end

  // ****************************************
  // Diagnostic capture.
  // ****************************************
  // Keeps the last translated address and the address that faulted.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_addr <= 24'h000000;
      trap_ea <= 16'h0000;
    end else begin
      if (wr_req) begin
        last_addr <= upper ? write_ext : {8'h00, ea};
      end else if (rd_req & ~read_trap) begin
        last_addr <= upper ? read_ext : {8'h00, ea};
      end
      if (read_trap) begin
        trap_ea <= ea;
      end
    end
  end

  // ****************************************
  // Page and mask registers.
  // ****************************************
  // Software sets both pages over the bus; narrower fields drop upper bits.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_read_page <= `READ_PAGE_RESET;
      data_write_page <= `WRITE_PAGE_RESET;
      mask <= {`ST_W{1'b0}};
    end else if (wr_en) begin
      if (wr_addr == `REG_READ_PAGE) begin
        data_read_page <= hwdata[`READ_PAGE_W-1:0];
      end
      if (wr_addr == `REG_WRITE_PAGE) begin
        data_write_page <= hwdata[`WRITE_PAGE_W-1:0];
      end
      if (wr_addr == `REG_MASK) begin
        mask <= hwdata[`ST_W-1:0];
      end
    end
  end

  // ****************************************
  // Sticky status and interrupt.
  // ****************************************
  // Writing a one clears a bit, but a new event in the same cycle wins.
  always @* begin
    next_status = status;
    if (wr_en && wr_addr == `REG_STATUS) begin
      next_status = status & ~hwdata[`ST_W-1:0];
    end
    if (read_trap) begin
      next_status[`ST_TRAP] = 1'b1;
    end
    if (read_psv) begin
      next_status[`ST_PSV] = 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= {`ST_W{1'b0}};
    end else begin
      status <= next_status;
    end
  end

  assign irq = |(status & mask);

  // ****************************************
  // Read data.
  // ****************************************
  // Read data is sampled in the address phase so it stands in the data phase.
  always @* begin
    next_rdata = 32'h00000000;
    case (rd_addr)
      `REG_READ_PAGE: next_rdata = {22'h000000, data_read_page};
      `REG_WRITE_PAGE: next_rdata = {23'h000000, data_write_page};
      `REG_STATUS: next_rdata = {30'h00000000, status};
      `REG_MASK: next_rdata = {30'h00000000, mask};
      `REG_LAST_ADDR: next_rdata = {8'h00, last_addr};
      `REG_TRAP_EA: next_rdata = {16'h0000, trap_ea};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_en) begin
      hrdata <= next_rdata;
    end
  end
endmodule

// ===== test/paged_core_model.sv
`timescale 1ns/1ps
// ****
// Core side.
// ****
module paged_core_model (
  // Clock.
  input logic hclk,
  // Load/store request.
  output logic acc_valid,
  output logic acc_write,
  output logic acc_word,
  output logic [2:0] acc_mode,
  output logic [15:0] acc_base
);
  // Quiet at time zero.
  initial begin
    {acc_valid, acc_write, acc_word, acc_mode, acc_base} = '0;
  end
  // Set after an edge and held until the edge that takes it.
  task issue(input logic wr, input logic wd, input logic [2:0] md, input logic [15:0] bs);
    acc_valid <= 1'b1;
    acc_write <= wr;
    acc_word <= wd;
    acc_mode <= md;
    acc_base <= bs;
    @(posedge hclk);
    #1;
  endtask
  // Released base shows its inverse, so no stale copy can pass.
  task idle;
    acc_valid <= 1'b0;
    acc_base <= ~acc_base;
  endtask
endmodule

// ===== test/paged_data_space_address_gen_assertions.sv
`timescale 1ns/1ps
// ****
// Port checker.
// ****
module paged_data_space_address_gen_assertions (
  // Clock and reset.
  input logic hclk,
  input logic hresetn,
  // Bus answer.
  input logic hreadyout,
  input logic hresp,
  // Core request.
  input logic acc_valid,
  input logic acc_write,
  input logic [2:0] acc_mode,
  input logic [15:0] acc_base,
  // Translated access.
  input logic mem_valid,
  input logic mem_write,
  input logic [23:0] mem_addr,
  input logic ptr_valid,
  input logic psv_valid,
  input logic addr_error_trap
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [15:0] base_q;
  logic rd_q;
  wire plain = acc_valid && acc_mode == 3'h0;
  // Request one edge back; only the pre modes modify the address.
  always @(posedge hclk) begin
    base_q <= acc_base;
    rd_q <= acc_valid && !acc_write;
  end
  // Every request answers one cycle later.
  property p_ptr; acc_valid |=> ptr_valid; endproperty
  a_ptr: assert property (p_ptr) else $error("no pointer");
  property p_one; mem_valid |-> $past(acc_valid); endproperty
  a_one: assert property (p_one) else $error("stray access");
  property p_low; plain && !acc_base[15] |=> mem_valid && mem_addr == {8'h00, base_q}; endproperty
  a_low: assert property (p_low) else $error("low half changed");
  property p_wr;
    plain && acc_write && acc_base[15] |=> mem_valid && mem_write && mem_addr[14:0] == base_q[14:0];
  endproperty
  a_wr: assert property (p_wr) else $error("bad write address");
  property p_rd;
    plain && !acc_write && acc_base[15] |=> addr_error_trap || psv_valid ||
      (mem_valid && !mem_write && mem_addr[14:0] == base_q[14:0]);
  endproperty
  a_rd: assert property (p_rd) else $error("bad read address");
  // A refused read never also reaches memory.
  property p_trap; addr_error_trap |-> rd_q && !mem_valid && !psv_valid; endproperty
  a_trap: assert property (p_trap) else $error("bad trap");
  property p_psv; psv_valid |-> rd_q && !mem_valid && !addr_error_trap; endproperty
  a_psv: assert property (p_psv) else $error("bad handoff");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready");
endmodule
bind paged_data_space_address_gen paged_data_space_address_gen_assertions i_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .acc_valid(acc_valid), .acc_write(acc_write), .acc_mode(acc_mode), .acc_base(acc_base),
  .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr), .ptr_valid(ptr_valid),
  .psv_valid(psv_valid), .addr_error_trap(addr_error_trap)
);

// ===== test/tb_paged_data_space_address_gen.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h seen %h", n, e, a); end end
// ****
// Bench.
// ****
module tb_paged_data_space_address_gen;
  logic hclk, hresetn, hsel, hwrite, w, wd, rdu, mv;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, m;
  logic [31:0] hwdata, r, e;
  logic [9:0] rp;
  logic [8:0] wp;
  logic [15:0] b, ea;
  wire hreadyout, hresp, mem_valid, mem_write, ptr_valid, psv_valid, addr_error_trap, irq;
  wire acc_valid, acc_write, acc_word;
  wire [2:0] acc_mode;
  wire [15:0] acc_base, ptr_update;
  wire [23:0] mem_addr, psv_addr;
  wire [31:0] hrdata;
  int miscompares, n_checks, i;
  paged_data_space_address_gen i_paged_data_space_address_gen (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_word(acc_word), .acc_mode(acc_mode), .acc_base(acc_base),
    .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
    .ptr_valid(ptr_valid), .ptr_update(ptr_update), .psv_valid(psv_valid),
    .psv_addr(psv_addr), .addr_error_trap(addr_error_trap), .irq(irq));
  paged_core_model i_paged_core_model (.hclk(hclk), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_word(acc_word), .acc_mode(acc_mode), .acc_base(acc_base));
  // Free-running clock.
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Bounded wait for ready, so a dead bus ends the run instead of hanging it.
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask
  // Address phase, then data phase; read data is taken at its closing edge.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  // Address used and pointer written back, packed as {address, pointer}.
  function logic [31:0] eaf(input logic [15:0] bs, input logic [2:0] md, input logic ww);
    logic [15:0] s;
    s = ww ? 16'h0002 : 16'h0001;
    case (md)
      3'h1: eaf = {bs + s, bs + s};
      3'h2: eaf = {bs - s, bs - s};
      3'h3: eaf = {bs, bs + s};
      3'h4: eaf = {bs, bs - s};
      default: eaf = {bs, bs};
    endcase
  endfunction
  // Main sequence: reset values, widths, random translations, then the interrupt.
  initial begin
    void'($urandom(11452));
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 7; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      `CHK("reset", (i < 2) ? 32'h1 : 32'h0, r)
    end
    bus(1'b1, 8'h00, 32'hffffffff);
    bus(1'b1, 8'h04, 32'hffffffff);
    bus(1'b0, 8'h00, 32'h0);
    `CHK("read page", 32'h3ff, r)
    bus(1'b0, 8'h04, 32'h0);
    `CHK("write page", 32'h1ff, r)
    hsize <= 3'h0;
    bus(1'b1, 8'h04, 32'h0);
    hsize <= 3'h2;
    bus(1'b0, 8'h04, 32'h0);
    `CHK("byte write refused", 32'h1ff, r)
    for (i = 0; i < 64; i++) begin
      if (i % 4 == 0) begin
        i_paged_core_model.idle();
        rp = (i % 16 == 0) ? 10'h000 : 10'($urandom);
        wp = 9'($urandom);
        bus(1'b1, 8'h00, 32'(rp));
        bus(1'b1, 8'h04, 32'(wp));
      end
      {w, wd, b} = 18'($urandom);
      m = 3'($urandom % 5);
      if (i % 8 == 3) b = 16'h7fff;
      i_paged_core_model.issue(w, wd, m, b);
      e = eaf(b, m, wd);
      ea = e[31:16];
      rdu = !w && ea[15];
      mv = !(rdu && (rp == 10'h000 || rp[9]));
      `CHK("trap", rdu && rp == 10'h000, addr_error_trap)
      `CHK("mem", mv, mem_valid)
      `CHK("ptr", {1'b1, e[15:0]}, {ptr_valid, ptr_update})
      if (mv && !ea[15]) `CHK("low", {w, 8'h00, ea}, {mem_write, mem_addr})
      if (mv && ea[15] && w) `CHK("wr", {wp, ea[14:0]}, mem_addr)
      if (mv && rdu) `CHK("rd", {rp[8:0], ea[14:0]}, mem_addr)
      `CHK("psv", rdu && rp[9], psv_valid)
      if (rdu && rp[9]) `CHK("psv addr", {rp[8:0], ea[14:0]}, psv_addr)
    end
    i_paged_core_model.idle();
    bus(1'b1, 8'h0c, 32'h1);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h08, 32'h3);
    for (i = 0; i < 2; i++) begin
      i_paged_core_model.issue(1'b0, 1'b0, 3'h0, 16'h9000);
      i_paged_core_model.idle();
      @(posedge hclk);
      #1;
      `CHK("irq", i == 0, irq)
      bus(1'b0, 8'h08, 32'h0);
      `CHK("status", 32'h1, r)
      bus(1'b0, 8'h14, 32'h0);
      `CHK("trap ea", 32'h9000, r)
      bus(1'b1, 8'h08, 32'h1);
      #1;
      `CHK("irq clear", 1'b0, irq)
      bus(1'b1, 8'h0c, 32'h0);
    end
    finish_test();
  end
  // Watchdog for the whole run.
  initial begin
    #2000000;
    miscompares++;
    finish_test();
  end
endmodule
